// *** rtl/amp_mapper.sv ***
// Maps a gateway process image onto consecutive 8-byte PDOs
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs.svh"

// =====================================================

module amp_mapper
    import amp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic mode_supp_i,
    input wire logic mbx_off_i,
    input wire logic [1:0] size_sel_i,
    input wire logic [2:0] mbx_len_i,
    input wire logic reduced_i,
    input wire logic [7:0] status_i,
    input wire logic [47:0] mbx_data_i,
    input wire logic [383:0] image_i,
    output logic pdo_valid_o,
    input wire logic pdo_ready_i,
    output logic [63:0] pdo_data_o,
    output logic [2:0] pdo_index_o,
    output logic pdo_last_o,
    output logic busy_o,
    output logic done_o
);

    // =====================================================
    // Helper functions
    // Image size in bytes for a size code
    function automatic logic [5:0] size_bytes(input amp_size_t s);
        logic [5:0] b;
        b = `AMP_SIZE_12;
        unique case (s)
            AMP_IMG_12: b = `AMP_SIZE_12;
            AMP_IMG_20: b = `AMP_SIZE_20;
            AMP_IMG_24: b = `AMP_SIZE_24;
            AMP_IMG_32: b = `AMP_SIZE_32;
        endcase
        return b;
    endfunction

    // Objects occupied; identical in both modes
    function automatic logic [2:0] pdo_count(input amp_size_t s);
        logic [2:0] c;
        c = 3'h2;
        unique case (s)
            AMP_IMG_12: c = 3'h2;
            AMP_IMG_20: c = 3'h3;
            AMP_IMG_24: c = 3'h3;
            AMP_IMG_32: c = 3'h4;
        endcase
        return c;
    endfunction

    // One image byte by index
    function automatic logic [7:0] img_byte(input logic [383:0] pd, input logic [5:0] off);
        return pd[{off, 3'b000} +: 8];
    endfunction

    // Assemble one object from the image, mailbox and status
    function automatic logic [63:0] build_word(
        input logic [2:0] idx,
        input amp_mode_t md,
        input logic moff,
        input logic [2:0] mlen,
        input logic [5:0] lim,
        input logic [7:0] stat,
        input logic [47:0] mbx,
        input logic [383:0] pd
    );
        logic [63:0] w;
        logic [5:0] off;
        logic [5:0] base;
        w = '0;
        off = '0;
        base = (md == AMP_MODE_SUPP) ? `AMP_PD_BASE_SUPP : 6'h00;
        for (int j = 0; j < `AMP_PDO_BYTES; j++) begin
            if (idx == 3'h0) begin
                if (j == `AMP_STAT_POS) begin
                    w[j*8 +: 8] = stat;
                end else if (j == `AMP_EMPTY_POS) begin
                    w[j*8 +: 8] = `AMP_EMPTY_BYTE;
                end else if (md == AMP_MODE_SUPP && moff) begin
                    w[j*8 +: 8] = img_byte(pd, 6'(j - `AMP_PAYLOAD_POS));
                end else if (3'(j - `AMP_PAYLOAD_POS) < mlen) begin
                    w[j*8 +: 8] = mbx[(j-`AMP_PAYLOAD_POS)*8 +: 8];
                end
            end else begin
                // Bytes past the image limit stay zero as reserved
                off = 6'(base + {idx - 3'h1, 3'b000} + 6'(j));
                if (off < lim) begin
                    w[j*8 +: 8] = img_byte(pd, off);
                end
            end
        end
        return w;
    endfunction

    // =====================================================
    // Configuration captured at start
    amp_state_t state_reg;
    amp_mode_t mode_reg;
    amp_size_t size_reg;
    logic moff_reg;
    logic [2:0] mlen_reg;
    logic [2:0] idx_reg;
    logic done_reg;
    logic busy_reg;
    logic [2:0] mlen_next;
    logic [5:0] lim;
    logic [2:0] count;
    logic [63:0] word;
    logic last;
    logic buf_ready;
    logic push;
    logic [67:0] buf_out;

    // Mailbox longer than six is clamped; the length field can code seven
    assign mlen_next = (mbx_len_i > `AMP_MBX_MAX) ? `AMP_MBX_MAX : mbx_len_i;
    // Process data bytes available beyond the first object's fixed part
    assign lim = size_bytes(size_reg) -
                 ((mode_reg == AMP_MODE_SUPP) ? `AMP_PD_SKIP_SUPP : `AMP_PD_SKIP_PERM);
    assign count = pdo_count(size_reg);
    assign word = build_word(idx_reg, mode_reg, moff_reg, mlen_reg, lim, status_i, mbx_data_i, image_i);
    assign last = (idx_reg == 3'(count - 3'h1));
    assign push = (state_reg == AMP_SEND) && buf_ready;

    // Capture configuration; image data is read live and must hold while busy
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= AMP_MODE_PERM;
            size_reg <= AMP_IMG_12;
            moff_reg <= 1'b0;
            mlen_reg <= 3'h0;
        end else if (state_reg == AMP_IDLE && start_i) begin
            mode_reg <= amp_mode_t'(mode_supp_i);
            size_reg <= amp_size_t'(size_sel_i);
            moff_reg <= mbx_off_i;
            mlen_reg <= mlen_next;
        end
    end

    // Sequencer: one object per accepted buffer slot, stop at the last
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= AMP_IDLE;
            idx_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                AMP_IDLE: begin
                    idx_reg <= 3'h0;
                    if (start_i) begin
                        state_reg <= AMP_SEND;
                    end
                end
                AMP_SEND: begin
                    if (push) begin
                        if (last) begin
                            state_reg <= AMP_IDLE;
                            idx_reg <= 3'h0;
                        end else begin
                            idx_reg <= idx_reg + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Status flags
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            done_reg <= push && last;
            busy_reg <= (state_reg == AMP_IDLE) ? start_i : !(push && last);
        end
    end

    assign done_o = done_reg;
    assign busy_o = busy_reg;

    // =====================================================
    // Output buffer, so a stalled receiver drops no object
    amp_buf #(
        .WIDTH(`AMP_ENTRY_BITS)
    ) u_buf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(state_reg == AMP_SEND),
        .in_ready_o(buf_ready),
        .in_data_i({last, idx_reg, word}),
        .out_valid_o(pdo_valid_o),
        .out_ready_i(pdo_ready_i),
        .out_data_o(buf_out)
    );

    assign pdo_data_o = buf_out[63:0];
    assign pdo_index_o = buf_out[66:64];
    assign pdo_last_o = buf_out[67];

    // =====================================================
    // Checks
    obj_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        push |-> ({idx_reg, 3'b000} + 6'(`AMP_PDO_BYTES)) <= `AMP_IMG_MAX)
        else $error("object beyond the image window");

    img_total_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        push |-> {3'b000, count, 3'b000} <= {3'b000, `AMP_IMG_MAX})
        else $error("image exceeds total limit");

    reduced_lim_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && reduced_i) |-> ({count, 3'b000} <= `AMP_IMG_MAX_RED) && (mlen_reg <= `AMP_MBX_MAX))
        else $error("reduced variant limits broken");

    first_obj_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && idx_reg == 3'h0) |-> (word[15:0] == {`AMP_EMPTY_BYTE, status_i}))
        else $error("first object header wrong");

    later_obj_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && idx_reg == 3'h1 && mode_reg == AMP_MODE_PERM) |-> word[7:0] == image_i[7:0])
        else $error("second object does not start with process data");

    empty_mbx_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && idx_reg == 3'h0 && mode_reg == AMP_MODE_PERM && mlen_reg == 3'h0) |-> word[63:16] == '0)
        else $error("empty mailbox object carries payload");

    seq_end_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && last) |=> done_o && (state_reg == AMP_IDLE) ##1 !done_o)
        else $error("sequence did not end at the object boundary");

    small_img_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && mode_reg == AMP_MODE_PERM && size_reg == AMP_IMG_12 && idx_reg == 3'h1)
        |-> word[63:32] == '0 && word[31:0] == image_i[31:0] && last)
        else $error("12-byte image second object wrong");

    mid_img_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && mode_reg == AMP_MODE_PERM && size_reg == AMP_IMG_20 && idx_reg == 3'h2)
        |-> word[63:32] == '0 && word[31:0] == image_i[95:64])
        else $error("20-byte image third object wrong");

    b_slave_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && mode_reg == AMP_MODE_PERM && size_reg == AMP_IMG_32 && idx_reg == 3'h3)
        |-> word == image_i[191:128] && last)
        else $error("fourth object wrong");

    supp_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && idx_reg == 3'h0 && mode_reg == AMP_MODE_SUPP && moff_reg) |-> word[63:16] == image_i[47:0])
        else $error("suppressed mailbox data wrong");

    overlay_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (push && idx_reg == 3'h1 && mode_reg == AMP_MODE_SUPP) |-> word[7:0] == image_i[55:48])
        else $error("overlaid process data leaked");

endmodule // amp_mapper

`default_nettype wire

// *** pkg/amp_regs.svh ***
// Constants for the process-image to PDO mapper
`ifndef AMP_REGS_SVH
`define AMP_REGS_SVH

// =====================================================
// Object layout
`define AMP_PDO_BYTES      8
`define AMP_PDO_BITS       64
`define AMP_STAT_POS       0
`define AMP_EMPTY_POS      1
`define AMP_PAYLOAD_POS    2
`define AMP_MBX_MAX        3'h6
`define AMP_MBX_BYTES      6
`define AMP_EMPTY_BYTE     8'h00

// =====================================================
// Image limits, in bytes, and image width in bits
`define AMP_IMG_MAX        6'h30
`define AMP_IMG_MAX_RED    6'h20
`define AMP_IMG_BITS       384

// =====================================================
// Image sizes and where process data starts in each mode
`define AMP_SIZE_12        6'h0c
`define AMP_SIZE_20        6'h14
`define AMP_SIZE_24        6'h18
`define AMP_SIZE_32        6'h20
`define AMP_PD_SKIP_PERM   6'h08
`define AMP_PD_SKIP_SUPP   6'h02
`define AMP_PD_BASE_SUPP   6'h06

// =====================================================
// Buffer entry width: data, index, last flag
`define AMP_ENTRY_BITS     68

`endif

// *** pkg/amp_pkg.sv ***
// Types of the process-image to PDO mapper
`default_nettype none

package amp_pkg;

    typedef enum logic {
        AMP_IDLE,
        AMP_SEND
    } amp_state_t;

    typedef enum logic {
        AMP_MODE_PERM,
        AMP_MODE_SUPP
    } amp_mode_t;

    typedef enum logic [1:0] {
        AMP_IMG_12,
        AMP_IMG_20,
        AMP_IMG_24,
        AMP_IMG_32
    } amp_size_t;

endpackage

`default_nettype wire

// *** rtl/amp_buf.sv ***
// Two-entry buffer with registered head for the PDO stream
`timescale 1ns/1ps
`default_nettype none

module amp_buf #(
    parameter int WIDTH = 68
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    // =====================================================
    // Storage
    logic head_v_reg;
    logic skid_v_reg;
    logic [WIDTH-1:0] head_d_reg;
    logic [WIDTH-1:0] skid_d_reg;
    logic push;
    logic pop;

    // Ready comes from a flop so the producer sees no combinational path
    assign in_ready_o = ~skid_v_reg;
    assign out_valid_o = head_v_reg;
    assign out_data_o = head_d_reg;
    assign push = in_valid_i & ~skid_v_reg;
    assign pop = head_v_reg & out_ready_i;

    // Head refills from the spare first, so order is kept
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            head_v_reg <= 1'b0;
            skid_v_reg <= 1'b0;
            head_d_reg <= '0;
            skid_d_reg <= '0;
        end else if (!head_v_reg || pop) begin
            if (skid_v_reg) begin
                head_d_reg <= skid_d_reg;
                head_v_reg <= 1'b1;
                skid_v_reg <= 1'b0;
            end else begin
                head_v_reg <= push;
                if (push) begin
                    head_d_reg <= in_data_i;
                end
            end
        end else if (push) begin
            skid_v_reg <= 1'b1;
            skid_d_reg <= in_data_i;
        end
    end

endmodule // amp_buf

`default_nettype wire

// *** tb/amp_sink.sv ***
// Behavioural fieldbus master that takes PDOs from the mapper
`timescale 1ns/1ps
`default_nettype none

module amp_sink (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic stall_i,
    input wire logic clear_i,
    input wire logic pdo_valid_i,
    input wire logic [63:0] pdo_data_i,
    input wire logic [2:0] pdo_index_i,
    input wire logic pdo_last_i,
    output logic pdo_ready_o
);
    logic [63:0] rx_data [0:7];
    logic [2:0] rx_index [0:7];
    logic rx_last [0:7];
    int rx_count = 0;
    logic [1:0] phase_reg;

    // ==========================================
    // Ready pattern
    // Stalling raises ready one cycle in four, so the two-entry buffer fills and the sequencer must wait
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg <= 2'h0;
            pdo_ready_o <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            pdo_ready_o <= !stall_i || (phase_reg == 2'h3);
        end
    end

    // Each accepted object is taken whole; the link carries eight bytes at most
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            rx_count <= 0;
        end else if (rstn_i && pdo_valid_i && pdo_ready_o) begin
            if (rx_count < 8) begin
                rx_data[rx_count] <= pdo_data_i;
                rx_index[rx_count] <= pdo_index_i;
                rx_last[rx_count] <= pdo_last_i;
            end
            rx_count <= rx_count + 1;
        end
    end
endmodule // amp_sink

`default_nettype wire

// *** tb/tb_amp_mapper.sv ***
// Self-checking bench for the process-image to PDO mapper
`timescale 1ns/1ps
`default_nettype none

module tb_amp_mapper;
    import amp_pkg::*;

    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic start_i = 1'b0;
    logic mode_supp_i = 1'b0;
    logic mbx_off_i = 1'b0;
    logic [1:0] size_sel_i = 2'h0;
    logic [2:0] mbx_len_i = 3'h0;
    logic reduced_i = 1'b0;
    logic [7:0] status_i = 8'h00;
    logic [47:0] mbx_data_i = '0;
    logic [383:0] image_i = '0;
    logic stall_i = 1'b0;
    logic clear_i = 1'b0;
    logic pdo_valid_o;
    logic pdo_ready_i;
    logic [63:0] pdo_data_o;
    logic [2:0] pdo_index_o;
    logic pdo_last_o;
    logic busy_o;
    logic done_o;
    int num_errors = 0;
    int check_count = 0;

    // ==========================================
    // Clock, design and far side
    always #2.5 clk_i = !clk_i;

    amp_mapper i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .mode_supp_i(mode_supp_i),
        .mbx_off_i(mbx_off_i), .size_sel_i(size_sel_i), .mbx_len_i(mbx_len_i), .reduced_i(reduced_i),
        .status_i(status_i), .mbx_data_i(mbx_data_i), .image_i(image_i), .pdo_valid_o(pdo_valid_o),
        .pdo_ready_i(pdo_ready_i), .pdo_data_o(pdo_data_o), .pdo_index_o(pdo_index_o),
        .pdo_last_o(pdo_last_o), .busy_o(busy_o), .done_o(done_o));

    amp_sink i_sink (.clk_i(clk_i), .rstn_i(rstn_i), .stall_i(stall_i), .clear_i(clear_i),
        .pdo_valid_i(pdo_valid_o), .pdo_data_i(pdo_data_o), .pdo_index_i(pdo_index_o),
        .pdo_last_i(pdo_last_o), .pdo_ready_o(pdo_ready_i));

    // ==========================================
    // Reporting
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Expected object, built byte by byte from the layout of each mode
    function automatic logic [63:0] exp_obj(input int k, input logic supp, input logic moff, input int ml,
        input int sz);
        logic [63:0] o;
        int j;
        int off;
        o = '0;
        if (k == 0) begin
            o[7:0] = status_i;
            for (j = 0; j < 6; j++) begin
                if (supp && moff) o[8*(j+2)+:8] = image_i[8*j+:8];
                else if (j < ml) o[8*(j+2)+:8] = mbx_data_i[8*j+:8];
            end
        end else begin
            for (j = 0; j < 8; j++) begin
                off = supp ? 6 + 8*(k-1) + j : 8*(k-1) + j;
                if (off < sz - (supp ? 2 : 8)) o[8*j+:8] = image_i[8*off+:8];
            end
        end
        return o;
    endfunction

    // ==========================================
    // One mapping sequence, optionally with a stalling receiver and a start issued while busy
    task automatic run_seq(input logic supp, input logic moff, input logic [1:0] sel, input logic [2:0] len,
        input logic stall, input logic extra, input logic [7:0] salt);
        int cnt;
        int sz;
        int n;
        int ml;
        cnt = (sel == 2'h0) ? 2 : (sel == 2'h3) ? 4 : 3;
        sz = (sel == 2'h0) ? 12 : (sel == 2'h1) ? 20 : (sel == 2'h2) ? 24 : 32;
        ml = (len > 3'h6) ? 6 : int'(len);
        // Stimulus changes on a rising edge only
        @(posedge clk_i);
        clear_i <= 1'b1;
        stall_i <= stall;
        mode_supp_i <= supp;
        mbx_off_i <= moff;
        size_sel_i <= sel;
        mbx_len_i <= len;
        status_i <= salt ^ 8'ha5;
        for (n = 0; n < 48; n++) image_i[8*n+:8] <= salt + 8'(n);
        for (n = 0; n < 6; n++) mbx_data_i[8*n+:8] <= 8'hc0 + salt + 8'(n);
        @(posedge clk_i);
        clear_i <= 1'b0;
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        // Object 0 sits in the buffer head one edge after the sequencer starts
        @(posedge clk_i);
        start_i <= extra;
        #1 check(busy_o, 1'h1, "busy after start");
        check(pdo_valid_o, 1'h1, "first object late");
        check(pdo_index_o, 3'h0, "first index");
        for (n = 0; n < 200; n++) begin
            if (done_o === 1'b1) break;
            @(posedge clk_i);
            start_i <= 1'b0;
            #1;
        end
        if (n == 200) begin
            num_errors++;
            $display("CHECK FAILED at %0t: no done within limit", $time);
            complete_run();
        end
        check(busy_o, 1'h0, "busy at done");
        for (n = 0; n < 200 && i_sink.rx_count < cnt; n++) @(posedge clk_i);
        repeat (6) @(posedge clk_i);
        #1 check(i_sink.rx_count, cnt, "object count");
        check(pdo_valid_o, 1'h0, "object after last");
        check(done_o, 1'h0, "second done");
        for (n = 0; n < cnt; n++) begin
            check(i_sink.rx_index[n], n[2:0], "index order");
            check(i_sink.rx_last[n], n == cnt - 1, "last flag");
            check(i_sink.rx_data[n], exp_obj(n, supp, moff, ml, sz), "object bytes");
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic s_reset();
        #1 check({pdo_valid_o, busy_o, done_o}, 3'h0, "outputs in reset");
    endtask

    task automatic s_perm_12_full();
        run_seq(1'b0, 1'b0, 2'h0, 3'h6, 1'b0, 1'b0, 8'h11);
    endtask

    task automatic s_perm_20_empty_mbx();
        run_seq(1'b0, 1'b0, 2'h1, 3'h0, 1'b0, 1'b0, 8'h22);
    endtask

    task automatic s_perm_24_stall();
        run_seq(1'b0, 1'b0, 2'h2, 3'h3, 1'b1, 1'b1, 8'h33);
    endtask

    task automatic s_perm_32_reduced();
        @(posedge clk_i);
        reduced_i <= 1'b1;
        run_seq(1'b0, 1'b0, 2'h3, 3'h7, 1'b0, 1'b0, 8'h44);
        @(posedge clk_i);
        reduced_i <= 1'b0;
    endtask

    task automatic s_supp_off();
        run_seq(1'b1, 1'b1, 2'h0, 3'h6, 1'b0, 1'b0, 8'h55);
        run_seq(1'b1, 1'b1, 2'h1, 3'h2, 1'b1, 1'b0, 8'h66);
    endtask

    task automatic s_supp_on();
        run_seq(1'b1, 1'b0, 2'h2, 3'h6, 1'b0, 1'b0, 8'h77);
        run_seq(1'b1, 1'b0, 2'h3, 3'h4, 1'b1, 1'b1, 8'h88);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        s_reset();
        s_perm_12_full();
        s_perm_20_empty_mbx();
        s_perm_24_stall();
        s_perm_32_reduced();
        s_supp_off();
        s_supp_on();
        complete_run();
    end
endmodule // tb_amp_mapper

`default_nettype wire
